// ===== dv/tb_vcs_crtc.sv
// self-checking bench for the crtc scan, underline, blank and sync block
// assumes the raw sync source model drives the sync inputs
`timescale 1ns/1ps
module tb_vcs_crtc;
  typedef struct {int k; logic [15:0] v;} vcs_note_s;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, max_scan_bit5 = 1'b0, overflow_bit3 = 1'b0;
  logic native_mode = 1'b0, text_mode = 1'b0, char_clk_en = 1'b0;
  logic frame_start = 1'b0, line_start = 1'b0;
  logic [9:0] scan_line = 10'h000;
  logic [4:0] char_row = 5'h00;
  logic hsync_in, vsync_in, hsync, vsync, vblank, underline;
  logic [15:0] fb_addr;
  int mismatches = 0, compares = 0;
  vcs_note_s notes[$];
  vcs_note_s n;

  always #12.5 mclk = ~mclk;

  vcs_crtc u_dut (.mclk, .nrst, .reg_index, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .max_scan_bit5, .overflow_bit3, .native_mode, .text_mode, .char_clk_en, .frame_start,
    .line_start, .scan_line, .char_row, .hsync_in, .vsync_in, .hsync, .vsync, .vblank,
    .underline, .fb_addr);
  vcs_sync_src u_src (.mclk(mclk), .rst_n(nrst), .hsync_raw(hsync_in), .vsync_raw(vsync_in));

  task automatic cmp_out(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_out

  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    cmp_out({8'h00, g}, {8'h00, e});
  endtask : cmp_reg

  task automatic cmp_addr(input logic [15:0] g, input logic [15:0] e);
    cmp_out(g, e);
  endtask : cmp_addr

  task automatic cmp_ul(input logic g, input logic e);
    cmp_out({15'h0, g}, {15'h0, e});
  endtask : cmp_ul

  task automatic cmp_vb(input logic g, input logic e);
    cmp_out({15'h0, g}, {15'h0, e});
  endtask : cmp_vb

  task automatic cmp_sync(input logic [1:0] g, input logic [1:0] e);
    cmp_out({14'h0, g}, {14'h0, e});
  endtask : cmp_sync

  // outputs settle after the edge, so notes are judged at the falling edge
  always @(negedge mclk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.k)
        0: cmp_reg(reg_rdata, n.v[7:0]);
        1: cmp_addr(fb_addr, n.v);
        2: cmp_ul(underline, n.v[0]);
        3: cmp_vb(vblank, n.v[0]);
        default: cmp_sync({hsync, vsync}, n.v[1:0]);
      endcase
    end
  end

  task automatic note(input int k, input logic [15:0] v);
    notes.push_back('{k, v});
  endtask : note

  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask : tick

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    reg_index <= i;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    reg_index <= i;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    note(0, {8'h00, e});
    tick(1);
  endtask : rd

  task automatic pulse();
    char_clk_en <= 1'b1;
    tick(1);
    char_clk_en <= 1'b0;
    tick(1);
  endtask : pulse

  task automatic frame();
    frame_start <= 1'b1;
    tick(1);
    frame_start <= 1'b0;
  endtask : frame

  task automatic line(input logic [9:0] s, input logic e);
    scan_line <= s;
    line_start <= 1'b1;
    tick(1);
    line_start <= 1'b0;
    tick(1);
    note(3, {15'h0, e});
  endtask : line

  function automatic logic [7:0] msk(input logic [7:0] i);
    case (i)
      8'h14: msk = 8'h7f;
      8'h15, 8'h16: msk = 8'hff;
      8'h17: msk = 8'hef;
      default: msk = 8'h00;
    endcase
  endfunction : msk

  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    tick(40000);
    mismatches++;
    finish_test();
  end

  initial begin
    logic [7:0] d, s;
    logic [9:0] b;
    void'($urandom(32'h98fb7e28));
    tick(10);
    nrst <= 1'b1;
    tick(3);
    for (int i = 8'h13; i <= 8'h18; i++) begin
      rd(i[7:0], 8'h00);
      d = 8'($urandom);
      wr(i[7:0], d);
      rd(i[7:0], d & msk(i[7:0]));
    end
    for (int p = 0; p < 3; p++) begin
      s = (p == 0) ? 8'h00 : 8'($urandom % 32);
      text_mode <= (p < 2);
      wr(8'h14, s);
      for (int r = 0; r < 32; r++) begin
        char_row <= r[4:0];
        tick(1);
        note(2, {15'h0, r == s && p < 2});
      end
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h14, {2'b00, m[1], 5'h00});
      wr(8'h17, {4'h4, m[0], 3'h0});
      frame();
      for (int k = 1; k <= 8; k++) begin
        pulse();
        note(1, 16'(k / (m == 2 ? 4 : m == 0 ? 1 : 2)));
      end
    end
    wr(8'h14, 8'h00);
    wr(8'h17, 8'h00);
    frame();
    repeat (8200) pulse();
    for (int a = 0; a < 4; a++) begin
      wr(8'h14, {1'b0, a == 3, 6'h0});
      wr(8'h17, {1'b0, a == 2, a == 1, 5'h0});
      tick(1);
      note(1, a == 0 ? 16'd16 : a == 1 ? 16'd16400 : a == 2 ? 16'd8200 : 16'd32800);
    end
    for (int v = 0; v < 4; v++) begin
      s = 8'($urandom);
      b = {v[1], v[0], s};
      max_scan_bit5 <= v[1];
      overflow_bit3 <= v[0];
      d = 8'($urandom % 8 + 2);
      wr(8'h15, s);
      wr(8'h16, s + d);
      line(b ^ 10'h100, 1'b0);
      line(b ^ 10'h200, 1'b0);
      line(b, 1'b1);
      line(b + 10'(d) - 10'h1, 1'b1);
      line(b + 10'(d), 1'b0);
    end
    for (int g = 0; g < 4; g++) begin
      native_mode <= g[1];
      wr(8'h17, {g[0], 7'h0});
      tick(4);
      repeat (8) begin
        tick(1);
        note(4, (g == 2) ? 16'h0 : {14'h0, hsync_in, vsync_in});
      end
      rd(8'h15, s);
    end
    tick(2);
    finish_test();
  end
endmodule : tb_vcs_crtc

// ===== dv/vcs_sync_src.sv
// raw sync source standing in for the timing logic beside the crtc
// assumes the mclk domain and the bench's active-low reset
`timescale 1ns/1ps
module vcs_sync_src (
  input wire logic mclk,
  input wire logic rst_n,
  output logic hsync_raw,
  output logic vsync_raw
);
  logic [3:0] cnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // hsync toggles every cycle pair and vsync every eight cycles, so a stuck gate shows within a few cycles
  assign hsync_raw = cnt_q[1];
  assign vsync_raw = cnt_q[3];
endmodule : vcs_sync_src

// ===== hdl/vcs_addr_step.sv
// memory address counter with character clock prescale
// assumes char_clk_en is a one-cycle pulse on mclk
`timescale 1ns/1ps
module vcs_addr_step (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic char_clk_en,
  input wire logic frame_start,
  input wire logic by_four,
  input wire logic by_two,
  output logic [15:0] ma
);
  typedef struct packed {
    logic [1:0] div;
    logic [15:0] ma;
  } vcs_step_s;
  vcs_step_s s_q;
  vcs_step_s s_d;
  logic [1:0] limit;

  always_comb begin
    s_d = s_q;
    limit = vcs_pkg::step_limit(by_four, by_two);
    if (frame_start) begin
      s_d.div = 2'h0;
      s_d.ma = 16'h0000;
    end else if (char_clk_en) begin
      // RULE1 step interval
      if (s_q.div >= limit) begin
        s_d.div = 2'h0;
        s_d.ma = s_q.ma + 16'h0001;
      end else begin
        s_d.div = s_q.div + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ma = s_q.ma;

  // divide by four: only steps after the fourth clock
  AST_STEP_FOUR: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    (char_clk_en && !frame_start && by_four && !by_two && s_q.div == 2'h1)
      |=> $stable(s_q.ma))
    else $error("counter stepped early in divide-by-four");
  AST_STEP_ONE: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    (char_clk_en && !frame_start && !by_four && !by_two)
      |=> (s_q.ma == $past(s_q.ma) + 16'h0001))
    else $error("counter missed a step in every-clock mode");
endmodule : vcs_addr_step

// ===== hdl/vcs_crtc.sv
// crt controller scan addressing, underline, vertical blank and sync gate
// assumes indexed data port writes, scan_line and sync inputs from
// timing logic on mclk; native_mode is an asynchronous strap level
`timescale 1ns/1ps
module vcs_crtc (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic max_scan_bit5,
  input wire logic overflow_bit3,
  input wire logic native_mode,
  input wire logic text_mode,
  input wire logic char_clk_en,
  input wire logic frame_start,
  input wire logic line_start,
  input wire logic [9:0] scan_line,
  input wire logic [4:0] char_row,
  input wire logic hsync_in,
  input wire logic vsync_in,
  output logic hsync,
  output logic vsync,
  output logic vblank,
  output logic underline,
  output logic [15:0] fb_addr
);
  typedef struct packed {
    logic [7:0] ul;
    logic [7:0] vbs;
    logic [7:0] vbe;
    logic [7:0] mode;
    logic [7:0] rdata;
    logic hs;
    logic vs;
    logic vb;
    logic und;
    logic [15:0] fb;
    logic [1:0] nat;
  } vcs_top_s;

  vcs_top_s s_q;
  vcs_top_s s_d;
  logic [1:0] rst_ff_q;
  logic rst_n;
  logic [15:0] ma;
  logic [9:0] start10;
  logic force_off;
  logic word_mode;

  // reset released through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_ff_q <= 2'b00;
    end else begin
      rst_ff_q <= {rst_ff_q[0], 1'b1};
    end
  end
  assign rst_n = rst_ff_q[1];

  vcs_addr_step u_step (
    .mclk(mclk),
    .rst_n(rst_n),
    .char_clk_en(char_clk_en),
    .frame_start(frame_start),
    .by_four(s_q.ul[vcs_pkg::UL_COUNT4_BIT]),
    .by_two(s_q.mode[vcs_pkg::MODE_COUNT2_BIT]),
    .ma(ma)
  );

  always_comb begin
    s_d = s_q;
    // strap level: first flop feeds only the second
    s_d.nat = {s_q.nat[0], native_mode};
    if (reg_wr) begin
      if (reg_index == vcs_pkg::IDX_UNDERLINE) begin
        s_d.ul = reg_wdata & vcs_pkg::UL_RW_MASK;
      end else if (reg_index == vcs_pkg::IDX_VBLANK_START) begin
        s_d.vbs = reg_wdata;
      end else if (reg_index == vcs_pkg::IDX_VBLANK_END) begin
        s_d.vbe = reg_wdata;
      end else if (reg_index == vcs_pkg::IDX_MODE_CTRL) begin
        s_d.mode = reg_wdata & vcs_pkg::MODE_RW_MASK;
      end
    end
    if (reg_rd) begin
      if (reg_index == vcs_pkg::IDX_UNDERLINE) begin
        s_d.rdata = s_q.ul;
      end else if (reg_index == vcs_pkg::IDX_VBLANK_START) begin
        s_d.rdata = s_q.vbs;
      end else if (reg_index == vcs_pkg::IDX_VBLANK_END) begin
        s_d.rdata = s_q.vbe;
      end else if (reg_index == vcs_pkg::IDX_MODE_CTRL) begin
        s_d.rdata = s_q.mode;
      end else begin
        s_d.rdata = 8'h00;
      end
    end
    // RULE7 RULE8 sync gate
    s_d.hs = hsync_in & ~force_off;
    s_d.vs = vsync_in & ~force_off;
    // RULE11 RULE5 blank compare, start wins a tie with end
    if (line_start) begin
      if (scan_line == start10) begin
        s_d.vb = 1'b1;
      end else if (scan_line[7:0] == s_q.vbe) begin
        s_d.vb = 1'b0;
      end
    end
    // RULE2 RULE3 underline row match, row zero on top
    s_d.und = text_mode && (char_row == s_q.ul[vcs_pkg::UL_ROW_MSB:0]);
    // RULE9 RULE10 address shift and wrap
    if (s_q.ul[vcs_pkg::UL_DWORD_BIT]) begin
      s_d.fb = {ma[13:0], 2'b00};
    end else if (s_q.mode[vcs_pkg::MODE_BYTE_BIT]) begin
      s_d.fb = ma;
    end else if (!s_q.mode[vcs_pkg::MODE_WRAP_BIT]) begin
      s_d.fb = {ma[14:0], 1'b0} & vcs_pkg::WRAP_16K_MASK;
    end else begin
      s_d.fb = {ma[14:0], 1'b0};
    end
  end

  // RULE4 blank start assembly
  assign start10 = {max_scan_bit5, overflow_bit3, s_q.vbs};
  // RULE8 only native modes honour the bit
  assign force_off = s_q.nat[1] && !s_q.mode[vcs_pkg::MODE_SYNC_RELEASE_BIT];
  assign word_mode = !s_q.ul[vcs_pkg::UL_DWORD_BIT] && !s_q.mode[vcs_pkg::MODE_BYTE_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ul <= vcs_pkg::UL_RESET;
      s_q.vbs <= vcs_pkg::VBS_RESET;
      s_q.vbe <= vcs_pkg::VBE_RESET;
      s_q.mode <= vcs_pkg::MODE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign hsync = s_q.hs;
  assign vsync = s_q.vs;
  assign vblank = s_q.vb;
  assign underline = s_q.und;
  assign fb_addr = s_q.fb;

  // outputs are registered, so each check looks one cycle after its cause
  AST_SYNC_FORCED: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
    (s_q.nat[1] && !s_q.mode[vcs_pkg::MODE_SYNC_RELEASE_BIT]) |=> (!hsync && !vsync))
    else $error("sync not held inactive");

  AST_SYNC_RUNS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
    s_q.mode[vcs_pkg::MODE_SYNC_RELEASE_BIT]
      |=> (hsync == $past(hsync_in) && vsync == $past(vsync_in)))
    else $error("sync not passed in normal operation");

  AST_SYNC_NON_NATIVE: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    !s_q.nat[1] |=> (hsync == $past(hsync_in)))
    else $error("sync forced outside native mode");

  AST_VS_NON_NATIVE: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    !s_q.nat[1] |=> (vsync == $past(vsync_in)))
    else $error("vertical sync forced outside native mode");

  AST_VB_START: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
    (line_start && scan_line == {max_scan_bit5, overflow_bit3, s_q.vbs}) |=> vblank)
    else $error("blank did not start on start line");

  AST_VB_END: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    (line_start && scan_line[7:0] == s_q.vbe && scan_line != start10) |=> !vblank)
    else $error("blank did not end on end value");

  AST_VB_KEEP: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    (line_start && scan_line != start10 && scan_line[7:0] != s_q.vbe) |=> $stable(vblank))
    else $error("blank changed on a line matching neither value");

  AST_VB_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    !line_start |=> $stable(vblank))
    else $error("blank changed between lines");

  AST_UNDERLINE: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    (text_mode && char_row == s_q.ul[vcs_pkg::UL_ROW_MSB:0]) |=> underline)
    else $error("underline missing on selected row");

  AST_UNDERLINE_OTHER: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    (char_row != s_q.ul[vcs_pkg::UL_ROW_MSB:0]) |=> !underline)
    else $error("underline on a row not selected");

  AST_UNDERLINE_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    !text_mode |=> !underline)
    else $error("underline outside text mode");

  AST_UNDERLINE_TOP: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    (text_mode && char_row == 5'h00 && s_q.ul[vcs_pkg::UL_ROW_MSB:0] != 5'h00) |=> !underline)
    else $error("underline on top row without zero field");

  AST_UNDERLINE_TOP_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    (text_mode && char_row == 5'h00 && s_q.ul[vcs_pkg::UL_ROW_MSB:0] == 5'h00) |=> underline)
    else $error("underline missing on top row with zero field");

  AST_BYTE_MODE: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    (!s_q.ul[vcs_pkg::UL_DWORD_BIT] && s_q.mode[vcs_pkg::MODE_BYTE_BIT])
      |=> (fb_addr == $past(ma)))
    else $error("byte mode address shifted");

  AST_DWORD_MODE: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    s_q.ul[vcs_pkg::UL_DWORD_BIT] |=> (fb_addr == {$past(ma[13:0]), 2'b00}))
    else $error("dword mode address not shifted twice");

  AST_WORD_SHIFT: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    (word_mode && s_q.mode[vcs_pkg::MODE_WRAP_BIT])
      |=> (fb_addr == {$past(ma[14:0]), 1'b0}))
    else $error("word mode address not shifted once");

  AST_WRAP: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    (word_mode && !s_q.mode[vcs_pkg::MODE_WRAP_BIT]) |=> (fb_addr[15:14] == 2'b00))
    else $error("word mode address not wrapped");

  AST_WRAP_LOW: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    (word_mode && !s_q.mode[vcs_pkg::MODE_WRAP_BIT])
      |=> (fb_addr[13:0] == {$past(ma[12:0]), 1'b0}))
    else $error("wrapped word address lost its low bits");
endmodule : vcs_crtc

// ===== hdl/vcs_pkg.sv
// constants for the crt controller scan, underline and blanking block
// assumes a character clock enable, scan-line counter and sync sources
// from neighbouring timing logic on the same mclk domain
// Behaviour
// RULE1 - The address counter steps every 1, 2, 4 or 2 character clocks for count bits 00, 01, 10, 11.
// RULE2 - In text mode the underline shows on the box row given by the 5-bit underline field.
// RULE3 - Box rows count from the top, the top-most row matching an underline value of zero.
// RULE4 - Blank start is 10 bits: start register low, overflow bit 3 as bit 8, max-scan bit 5 as bit 9.
// RULE5 - Scan lines count from zero at the top, so the start value is the first blanked line.
// RULE6 - Software sets the 8-bit end value to the low byte of start plus the blanking length.
// RULE7 - With mode control bit 7 clear both syncs are held inactive, else timing runs normally.
// RULE8 - The sync forcing applies only in native non-centered modes and is ignored otherwise.
// RULE9 - Frame buffer address is the counter shifted once in word, not in byte, twice in dword mode.
// RULE10 - In word mode with the wrap bit clear the address wraps at 16 KB, otherwise no wrap.
// RULE11 - Blanking starts when the line equals the 10-bit start and ends when its low byte equals end.
package vcs_pkg;
  localparam logic [7:0] IDX_UNDERLINE = 8'h14;
  localparam logic [7:0] IDX_VBLANK_START = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END = 8'h16;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h17;
  // field positions
  localparam int UL_DWORD_BIT = 6;
  localparam int UL_COUNT4_BIT = 5;
  localparam int UL_ROW_MSB = 4;
  localparam int MODE_SYNC_RELEASE_BIT = 7;
  localparam int MODE_BYTE_BIT = 6;
  localparam int MODE_WRAP_BIT = 5;
  localparam int MODE_COUNT2_BIT = 3;
  // reserved bits read zero
  localparam logic [7:0] UL_RW_MASK = 8'h7f;
  localparam logic [7:0] MODE_RW_MASK = 8'hef;
  // reset values, undefined bits taken as zero
  localparam logic [7:0] UL_RESET = 8'h00;
  localparam logic [7:0] VBS_RESET = 8'h00;
  localparam logic [7:0] VBE_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // step limits: character clocks per step minus one
  localparam logic [1:0] STEP_EVERY_ONE = 2'h0;
  localparam logic [1:0] STEP_EVERY_TWO = 2'h1;
  localparam logic [1:0] STEP_EVERY_FOUR = 2'h3;
  localparam logic [15:0] WRAP_16K_MASK = 16'h3fff;

  function automatic logic [1:0] step_limit(input logic by_four, input logic by_two);
    if (by_four && !by_two) begin
      step_limit = STEP_EVERY_FOUR;
    end else if (by_four || by_two) begin
      step_limit = STEP_EVERY_TWO;
    end else begin
      step_limit = STEP_EVERY_ONE;
    end
  endfunction : step_limit
endpackage : vcs_pkg
